/* hw/mms_pkg.sv */
package mms_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned TICK_US     = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [10:0] PERIOD_MS_0P5 = 11'h7D0;
    localparam logic [10:0] PERIOD_MS_1   = 11'h3E8;
    localparam logic [10:0] PERIOD_MS_2   = 11'h1F4;
    localparam logic [10:0] PERIOD_MS_20  = 11'h032;
    localparam logic [10:0] PERIOD_MS_40  = 11'h019;
    localparam logic [10:0] PERIOD_MS_100 = 11'h00A;
    localparam logic [10:0] PERIOD_MS_500 = 11'h002;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_X_LO   = 8'h11;
    localparam logic [7:0] ADDR_X_HI   = 8'h12;
    localparam logic [7:0] ADDR_Y_LO   = 8'h13;
    localparam logic [7:0] ADDR_Y_HI   = 8'h14;
    localparam logic [7:0] ADDR_Z_LO   = 8'h15;
    localparam logic [7:0] ADDR_Z_HI   = 8'h16;
    localparam logic [7:0] ADDR_SET_LO = 8'h20;
    localparam logic [7:0] ADDR_CTRL1  = 8'h20;
    localparam logic [7:0] ADDR_MODE   = 8'h21;
    localparam logic [7:0] ADDR_SOFT_RST = 8'h22;
    localparam logic [7:0] ADDR_SET_HI = 8'h27;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned STAT_RDY_POS   = 0;
    localparam int unsigned STAT_OVR_POS   = 1;
    localparam int unsigned STAT_CLAMP_POS = 2;
    localparam int unsigned STAT_ADC_POS   = 3;
    localparam int unsigned DRIVE_POS      = 0;
    localparam int unsigned RANGE_POS      = 1;
    localparam int unsigned SOFT_RST_POS   = 0;
    localparam logic [3:0]  MODE_PDN     = 4'h0;
    localparam logic [3:0]  MODE_SINGLE  = 4'h1;
    localparam logic        DRIVE_RST    = 1'b0;
    localparam logic        RANGE_RST    = 1'b0;
    // lateral limits in counts: 36.04 mT / 1.1 uT, 34.91 mT / 3.1 uT
    localparam logic signed [15:0] LIMIT_HS = 16'sh7FFC;
    localparam logic signed [15:0] LIMIT_WR = 16'sh2BFD;

    typedef enum logic [1:0] {
        FSM_IDLE,
        FSM_MEASURE,
        FSM_PSAVE
    } mms_fsm_type;
endpackage : mms_pkg

/* hw/mms_lateral_clamp.sv */
`timescale 1ns/100ps
`default_nettype none
module mms_lateral_clamp
    import mms_pkg::*;
(
    input  wire logic [15:0] raw_x,
    input  wire logic [15:0] raw_y,
    input  wire logic        range_wide,
    output logic      [15:0] out_x,
    output logic      [15:0] out_y,
    output logic             clamp_flag
);
    // ------------------------------------------------------------
    // limit one axis, flag in the top bit
    // ------------------------------------------------------------
    function automatic logic [16:0] clamp_axis(
        input logic signed [15:0] v,
        input logic signed [15:0] lim
    );
        logic signed [15:0] nlim;
        nlim = -lim;
        if (v > lim) begin
            clamp_axis = {1'b1, lim};
        end else if (v < nlim) begin
            clamp_axis = {1'b1, nlim};
        end else begin
            clamp_axis = {1'b0, v};
        end
    endfunction : clamp_axis

    logic signed [15:0] lim;
    logic        [16:0] cx;
    logic        [16:0] cy;

    always_comb begin
        lim = range_wide ? LIMIT_WR : LIMIT_HS;
        cx = clamp_axis(raw_x, lim);
        cy = clamp_axis(raw_y, lim);
        out_x = cx[15:0];
        out_y = cy[15:0];
        clamp_flag = cx[16] | cy[16];
    end
endmodule : mms_lateral_clamp
`default_nettype wire

/* hw/mms_interval_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module mms_interval_timer
    import mms_pkg::*;
#(
    parameter int unsigned TICKS = TICK_CYCLES,
    parameter int unsigned PRE_W = 14,
    parameter int unsigned IVL_W = 11
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] rate_code,
    output logic            wake
);
    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [IVL_W-1:0] ivl;
        logic             wake;
    } mms_tmr_type;

    mms_tmr_type s;
    mms_tmr_type next_s;
    logic [IVL_W-1:0] reload;

    // ------------------------------------------------------------
    // reload chosen by rate
    // ------------------------------------------------------------
    always_comb begin
        case (rate_code)
            3'h0:    reload = IVL_W'(PERIOD_MS_0P5);
            3'h1:    reload = IVL_W'(PERIOD_MS_1);
            3'h2:    reload = IVL_W'(PERIOD_MS_2);
            3'h3:    reload = IVL_W'(PERIOD_MS_20);
            3'h4:    reload = IVL_W'(PERIOD_MS_40);
            3'h5:    reload = IVL_W'(PERIOD_MS_100);
            default: reload = IVL_W'(PERIOD_MS_500);
        endcase
        next_s = s;
        next_s.wake = 1'b0;
        if (!run || restart) begin
            next_s.pre = '0;
            next_s.ivl = '0;
        end else if (s.pre == PRE_W'(TICKS - 1)) begin
            next_s.pre = '0;
            if (s.ivl == reload - 1'b1) begin
                next_s.ivl  = '0;
                next_s.wake = 1'b1;
            end else begin
                next_s.ivl = s.ivl + 1'b1;
            end
        end else begin
            next_s.pre = s.pre + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wake = s.wake;
endmodule : mms_interval_timer
`default_nettype wire

/* hw/mms_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module mms_sequencer
    import mms_pkg::*;
#(
    parameter int unsigned TICKS = TICK_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        reset_pin_n,
    input  wire logic        chip_select_n,
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_addr,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic        acc_end,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_x,
    input  wire logic [15:0] conv_y,
    input  wire logic [15:0] conv_z,
    input  wire logic        conv_adc_ovf,
    output logic      [7:0]  acc_rdata,
    output logic             conv_start,
    output logic             power_save_state,
    output logic             drive_select_bit,
    output logic             range_select_bit,
    output logic             spi_select
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mms_fsm_type fsm;
        logic [3:0]  mode;
        logic        drive;
        logic        range;
        logic        halt;
        logic        rdy;
        logic        ovr;
        logic        clamp;
        logic        adcovf;
        logic        rd_active;
        logic        axis_done;
        logic        pend;
        logic [15:0] px;
        logic [15:0] py;
        logic [15:0] pz;
        logic        pclamp;
        logic        padc;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
        logic [7:0]  rdata;
        logic        conv_start;
        logic        restart;
        logic        psave;
        logic        spi_sel;
    } mms_top_type;

    mms_top_type s;
    mms_top_type next_s;

    function automatic logic is_cont(input logic [3:0] m);
        is_cont = (m[0] == 1'b0) && (m != MODE_PDN);
    endfunction : is_cont

    function automatic logic is_setting(input logic [7:0] a);
        is_setting = (a >= ADDR_SET_LO) && (a <= ADDR_SET_HI);
    endfunction : is_setting

    function automatic logic is_result(input logic [7:0] a);
        is_result = (a >= ADDR_X_LO) && (a <= ADDR_Z_HI);
    endfunction : is_result

    logic        tmr_wake;
    logic [15:0] cl_x;
    logic [15:0] cl_y;
    logic        cl_flag;
    logic        do_store;
    logic        meas_done;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    mms_interval_timer #(
        .TICKS (TICKS)
    ) u_timer (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .run       (s.fsm != FSM_IDLE && is_cont(s.mode)),
        .restart   (s.restart),
        .rate_code (3'(s.mode[3:1] - 3'h1)),
        .wake      (tmr_wake)
    );

    mms_lateral_clamp u_clamp (
        .raw_x      (conv_x),
        .raw_y      (conv_y),
        .range_wide (s.range),
        .out_x      (cl_x),
        .out_y      (cl_y),
        .clamp_flag (cl_flag)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        meas_done = conv_done && s.fsm == FSM_MEASURE;
        do_store  = 1'b0;
        next_s = s;
        next_s.conv_start = 1'b0;
        next_s.restart    = 1'b0;
        next_s.spi_sel    = ~chip_select_n;

        if (acc_valid && !acc_write) begin
            case (acc_addr)
                ADDR_STATUS: next_s.rdata = {4'h0, s.adcovf, s.clamp,
                                             s.ovr, s.rdy};
                ADDR_X_LO:   next_s.rdata = s.x[7:0];
                ADDR_X_HI:   next_s.rdata = s.x[15:8];
                ADDR_Y_LO:   next_s.rdata = s.y[7:0];
                ADDR_Y_HI:   next_s.rdata = s.y[15:8];
                ADDR_Z_LO:   next_s.rdata = s.z[7:0];
                ADDR_Z_HI:   next_s.rdata = s.z[15:8];
                ADDR_CTRL1:  next_s.rdata = {6'h00, s.range, s.drive};
                ADDR_MODE:   next_s.rdata = {4'h0, s.mode};
                default:     next_s.rdata = 8'h00;
            endcase
        end

        if (acc_valid && is_result(acc_addr)) begin
            next_s.rd_active = 1'b1;
            if (!acc_addr[0]) begin
                next_s.axis_done = 1'b1;
            end
        end

        if (acc_valid && is_setting(acc_addr)) begin
            next_s.rdy       = 1'b0;
            next_s.ovr       = 1'b0;
            next_s.rd_active = 1'b0;
            next_s.axis_done = 1'b0;
            next_s.halt      = 1'b1;
            if (acc_write && acc_addr == ADDR_CTRL1) begin
                next_s.drive = acc_wdata[DRIVE_POS];
                next_s.range = acc_wdata[RANGE_POS];
            end
            if (acc_write && acc_addr == ADDR_MODE) begin
                next_s.mode = acc_wdata[3:0];
                next_s.halt = 1'b0;
                next_s.pend  = 1'b0;
                next_s.psave = 1'b0;
                if (acc_wdata[3:0] == MODE_PDN) begin
                    next_s.fsm = FSM_IDLE;
                end else if (acc_wdata[3:0] == MODE_SINGLE ||
                             is_cont(acc_wdata[3:0])) begin
                    next_s.fsm        = FSM_MEASURE;
                    next_s.conv_start = 1'b1;
                    next_s.restart    = 1'b1;
                end else begin
                    next_s.fsm = FSM_IDLE;
                end
            end
        end

        if (acc_end) begin
            next_s.axis_done = 1'b0;
            if (s.rd_active && (s.axis_done ||
                (acc_valid && is_result(acc_addr) && !acc_addr[0]))) begin
                next_s.rdy       = 1'b0;
                next_s.ovr       = 1'b0;
                next_s.rd_active = 1'b0;
                if (s.pend) begin
                    next_s.x      = s.px;
                    next_s.y      = s.py;
                    next_s.z      = s.pz;
                    next_s.clamp  = s.pclamp;
                    next_s.adcovf = s.padc;
                    next_s.pend   = 1'b0;
                    next_s.rdy    = 1'b1;
                end
            end
        end

        if (meas_done && !next_s.halt) begin
            if (next_s.rd_active || next_s.pend) begin
                next_s.pend   = 1'b1;
                next_s.px     = cl_x;
                next_s.py     = cl_y;
                next_s.pz     = conv_z;
                next_s.pclamp = cl_flag;
                next_s.padc   = conv_adc_ovf;
            end else begin
                do_store = 1'b1;
                next_s.x = cl_x;
                next_s.y = cl_y;
                next_s.z = conv_z;
                next_s.clamp  = cl_flag;
                next_s.adcovf = conv_adc_ovf;
                next_s.ovr = next_s.rdy;
                next_s.rdy = 1'b1;
            end
        end
        if (meas_done && next_s.fsm == FSM_MEASURE) begin
            if (s.mode == MODE_SINGLE) begin
                next_s.mode = MODE_PDN;
                next_s.fsm  = FSM_IDLE;
            end else begin
                next_s.fsm   = FSM_PSAVE;
                next_s.psave = 1'b1;
            end
        end
        if (s.fsm == FSM_PSAVE && next_s.fsm == FSM_PSAVE && tmr_wake) begin
            next_s.fsm        = FSM_MEASURE;
            next_s.psave      = 1'b0;
            next_s.conv_start = 1'b1;
        end

        if (!reset_pin_n ||
            (acc_valid && acc_write && acc_addr == ADDR_SOFT_RST &&
             acc_wdata[SOFT_RST_POS])) begin
            next_s         = '0;
            next_s.drive   = DRIVE_RST;
            next_s.range   = RANGE_RST;
            next_s.mode    = MODE_PDN;
            next_s.spi_sel = ~chip_select_n;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign acc_rdata        = s.rdata;
    assign conv_start       = s.conv_start;
    assign power_save_state = s.psave;
    assign drive_select_bit = s.drive;
    assign range_select_bit = s.range;
    assign spi_select       = s.spi_sel;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic quiet;
    assign quiet = reset_pin_n && !acc_valid && !acc_end;

    chk_wake_start: assert property (
        s.fsm == FSM_PSAVE && tmr_wake && quiet
        |=> conv_start ##1 !conv_start && s.fsm == FSM_MEASURE)
        else $error("wake did not start a conversion");
    chk_ready_set: assert property (
        meas_done && quiet && !s.halt && !s.rd_active && !s.pend
        |=> s.rdy && s.x == $past(cl_x) && s.psave == is_cont(s.mode))
        else $error("ready not set on stored conversion");
    chk_setting_clr: assert property (
        acc_valid && is_setting(acc_addr) && !meas_done
        |=> !s.rdy && !s.ovr)
        else $error("setting access left ready set");
    chk_overrun_set: assert property (
        meas_done && quiet && s.rdy && !s.halt && !s.rd_active && !s.pend
        |=> s.ovr && s.rdy)
        else $error("overrun not flagged");
    chk_freeze_hold: assert property (
        s.rd_active && quiet |=> $stable(s.x) && $stable(s.z))
        else $error("results changed during read");
    chk_defer_set: assert property (
        meas_done && quiet && s.rd_active && !s.halt
        |=> s.pend && $stable(s.y) && $stable(s.ovr))
        else $error("new set not deferred");
    chk_single_end: assert property (
        meas_done && quiet && s.mode == MODE_SINGLE
        |=> s.mode == MODE_PDN && s.fsm == FSM_IDLE && !s.psave)
        else $error("single mode did not return");
    chk_reset_init: assert property (
        !reset_pin_n |=> s.mode == MODE_PDN && !s.rdy && !drive_select_bit)
        else $error("reset did not initialise");
    chk_iface_sel: assert property (
        ##1 spi_select == !$past(chip_select_n))
        else $error("interface select wrong");
    chk_mode_restart: assert property (
        acc_valid && acc_write && acc_addr == ADDR_MODE &&
        acc_wdata[3:0] == MODE_SINGLE && reset_pin_n
        |=> conv_start && $stable(s.x) && s.fsm == FSM_MEASURE)
        else $error("mode write did not restart");
endmodule : mms_sequencer
`default_nettype wire

/* dv/mms_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mms_conv_model (
    input  wire logic        core_clk,
    input  wire logic        conv_start,
    input  wire logic [7:0]  lat,
    input  wire logic [15:0] val_x,
    input  wire logic [15:0] val_y,
    input  wire logic [15:0] val_z,
    input  wire logic        val_ovf,
    output logic             conv_done,
    output logic      [15:0] conv_x,
    output logic      [15:0] conv_y,
    output logic      [15:0] conv_z,
    output logic             conv_adc_ovf
);
    logic [7:0] cnt = 8'h00;
    initial conv_done = 1'b0;
    // results only hold with the done pulse, scrambled otherwise
    assign conv_x       = conv_done ? val_x : ~val_x;
    assign conv_y       = conv_done ? val_y : ~val_y;
    assign conv_z       = conv_done ? val_z : ~val_z;
    assign conv_adc_ovf = conv_done ? val_ovf : ~val_ovf;
    always @(negedge core_clk) begin
        conv_done <= 1'b0;
        if (conv_start) begin
            cnt <= lat;
        end else if (cnt == 8'h01) begin
            conv_done <= 1'b1;
            cnt <= 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : mms_conv_model
`default_nettype wire

/* dv/magnetometer_measure_sequencer_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module magnetometer_measure_sequencer_tb_top;
    import mms_pkg::*;
    localparam int unsigned TK = 4;
    logic        core_clk = 1'b0, sys_rst = 1'b1, reset_pin_n = 1'b1;
    logic        chip_select_n = 1'b1, acc_valid = 1'b0;
    logic        acc_write = 1'b0, acc_end = 1'b0, vo = 1'b0;
    logic [7:0]  acc_addr = 8'h00, acc_wdata = 8'h00, lat = 8'h03;
    logic [15:0] vx = 16'h0000, vy = 16'h0000, vz = 16'h0000;
    logic        conv_done, conv_adc_ovf, conv_start, power_save_state;
    logic        drive_select_bit, range_select_bit, spi_select;
    logic [15:0] conv_x, conv_y, conv_z, t16, ox;
    logic [7:0]  acc_rdata;
    int          n_fail = 0, total_checks = 0, n, k;
    int unsigned per [7] = '{2000, 1000, 500, 50, 25, 10, 2};

    always #50 core_clk = ~core_clk;

    mms_sequencer #(.TICKS(TK)) mms_sequencer_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
        .chip_select_n(chip_select_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_end(acc_end), .conv_done(conv_done), .conv_x(conv_x),
        .conv_y(conv_y), .conv_z(conv_z), .conv_adc_ovf(conv_adc_ovf),
        .acc_rdata(acc_rdata), .conv_start(conv_start),
        .power_save_state(power_save_state),
        .drive_select_bit(drive_select_bit),
        .range_select_bit(range_select_bit), .spi_select(spi_select));
    mms_conv_model mms_conv_model_inst (
        .core_clk(core_clk), .conv_start(conv_start), .lat(lat),
        .val_x(vx), .val_y(vy), .val_z(vz), .val_ovf(vo),
        .conv_done(conv_done), .conv_x(conv_x), .conv_y(conv_y),
        .conv_z(conv_z), .conv_adc_ovf(conv_adc_ovf));

    function automatic logic [15:0] stv(input logic r, o, c, a);
        stv = 16'h0000;
        stv[STAT_RDY_POS] = r;
        stv[STAT_OVR_POS] = o;
        stv[STAT_CLAMP_POS] = c;
        stv[STAT_ADC_POS] = a;
    endfunction : stv
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge core_clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_addr = a;
        acc_wdata = d;
        @(negedge core_clk);
        acc_valid = 1'b0;
    endtask : acc
    task automatic fin;
        @(negedge core_clk);
        acc_end = 1'b1;
        @(negedge core_clk);
        acc_end = 1'b0;
    endtask : fin
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        acc(1'b0, a, 8'h00);
        v[7:0] = acc_rdata;
        acc(1'b0, a + 8'h01, 8'h00);
        v[15:8] = acc_rdata;
    endtask : rd16
    task automatic stat_chk(input logic [15:0] e);
        acc(1'b0, ADDR_STATUS, 8'h00);
        chk(16'(acc_rdata), e);
    endtask : stat_chk
    // bounded wait: 0 start, 1 power-save, 2 conversion done
    task automatic wt(input int s, input int mx, output int c);
        for (c = 1; c <= mx; c++) begin
            @(negedge core_clk);
            if ((s == 0 && conv_start === 1'b1) ||
                (s == 1 && power_save_state === 1'b1) ||
                (s == 2 && conv_done === 1'b1)) return;
        end
        n_fail++;
        results;
    endtask : wt
    task automatic quiet(input int cyc);
        int c;
        c = 0;
        repeat (cyc) begin
            @(negedge core_clk);
            if (conv_start !== 1'b0) c++;
        end
        chk(16'(c), 16'h0000);
    endtask : quiet

    initial begin
        void'($urandom(32'hDEEF));
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        chk(16'({range_select_bit, drive_select_bit}), 16'h0000);
        stat_chk(stv(0, 0, 0, 0));
        chip_select_n = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(16'(spi_select), 16'h0001);
        chip_select_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(16'(spi_select), 16'h0000);
        for (k = 0; k < 4; k++) begin
            acc(1'b1, ADDR_CTRL1, 8'(k));
            chk(16'({range_select_bit, drive_select_bit}), 16'(k));
        end
        for (k = 0; k < 7; k++) begin
            vx = 16'($urandom) & 16'h0FFF;
            acc(1'b1, ADDR_MODE, 8'(2 * k + 2));
            chk(16'(conv_start), 16'h0001);
            wt(0, per[k] * TK + 4, n);
            // first interval holds the restart, time the second
            wt(0, per[k] * TK + 4, n);
            chk(16'(n), 16'(per[k] * TK));
        end
        acc(1'b1, ADDR_MODE, 8'(MODE_PDN));
        quiet(40);
        stat_chk(stv(0, 0, 0, 0));
        vx = 16'h7FFF;
        vy = 16'($urandom) & 16'h0FFF;
        vz = 16'($urandom);
        vo = 1'b1;
        acc(1'b1, ADDR_MODE, 8'h0C);
        chk(16'(conv_start), 16'h0001);
        wt(1, 8, n);
        stat_chk(stv(1, 0, 1, 1));
        rd16(ADDR_X_LO, t16);
        chk(t16, LIMIT_WR);
        rd16(ADDR_Y_LO, t16);
        chk(t16, vy);
        rd16(ADDR_Z_LO, t16);
        chk(t16, vz);
        fin;
        stat_chk(stv(0, 0, 1, 1));
        vx = 16'($urandom) & 16'h0FFF;
        vo = 1'b0;
        wt(0, 48, n);
        wt(1, 8, n);
        stat_chk(stv(1, 0, 0, 0));
        wt(0, 48, n);
        wt(1, 8, n);
        stat_chk(stv(1, 1, 0, 0));
        rd16(ADDR_X_LO, t16);
        chk(t16, vx);
        fin;
        ox = vx;
        vx = 16'($urandom) & 16'h0FFF;
        lat = 8'd20;
        wt(0, 48, n);
        rd16(ADDR_X_LO, t16);
        chk(t16, ox);
        wt(1, 30, n);
        rd16(ADDR_X_LO, t16);
        chk(t16, ox);
        fin;
        stat_chk(stv(1, 0, 0, 0));
        rd16(ADDR_X_LO, t16);
        chk(t16, vx);
        fin;
        acc(1'b0, ADDR_CTRL1, 8'h00);
        ox = vx;
        vx = 16'($urandom) & 16'h0FFF;
        wt(0, 48, n);
        wt(1, 30, n);
        rd16(ADDR_X_LO, t16);
        chk(t16, ox);
        fin;
        stat_chk(stv(0, 0, 0, 0));
        acc(1'b1, ADDR_MODE, 8'h0C);
        chk(16'(conv_start), 16'h0001);
        wt(1, 30, n);
        rd16(ADDR_X_LO, t16);
        chk(t16, vx);
        fin;
        acc(1'b1, ADDR_MODE, 8'(MODE_SINGLE));
        chk(16'(conv_start), 16'h0001);
        wt(2, 30, n);
        repeat (2) @(negedge core_clk);
        stat_chk(stv(1, 0, 0, 0));
        acc(1'b0, ADDR_MODE, 8'h00);
        chk(16'(acc_rdata[3:0]), 16'(MODE_PDN));
        quiet(60);
        reset_pin_n = 1'b0;
        @(negedge core_clk);
        reset_pin_n = 1'b1;
        @(negedge core_clk);
        chk(16'({range_select_bit, drive_select_bit}), 16'h0000);
        stat_chk(stv(0, 0, 0, 0));
        rd16(ADDR_X_LO, t16);
        chk(t16, 16'h0000);
        results;
    end
endmodule : magnetometer_measure_sequencer_tb_top
`default_nettype wire
